// ---- verilog/adcoi_top.sv ----
// Converter output interface: restart, sample-ready pin, result latching, read checksum, write lock
// Functional notes
// - Phase write or osr/prescaler/clock/reference change restarts an active converter.
// - Restart clears result registers, then conversion resumes unaided.
// - Rewriting phase with same value soft-resets converter, independent of reset bit.
// - Sample-ready pulses low for half a modulator clock period per conversion.
// - First pulse after settling plus phase delay, then every output-rate period.
// - Idle sample-ready is high-impedance or driven high per tristate select.
// - Sample-ready pulses ignore chip select and serial activity.
// - Checksum mismatch holds sample-ready low.
// - First result latch captures data at sample-ready time.
// - Second latch captures at read start; data stable during read.
// - Ready flag reads 0 when new data is available; poll may read at once.
// - With checksum enabled, CRC follows each continuous read sequence.
// - Checksum is CRC-16, polynomial x^16+x^15+x^2+1.
// - Width bit picks 16 or 32 bit checksum word; value always 16 bits.
// - Checksum sent only after last address of the set, before wrap.
// - Lock key at 0x1F; while 0xA5 writes to every address except 0x00 accepted.
// - Lock key not 0xA5: only address 0x1F is writable.
`timescale 1ns/1ns
`include "adcoi_cfg.svh"
module adcoi_top import adcoi_pkg::*; #(
    parameter int MOD_DIV = 16,
    parameter int SETTLE_PERIODS = 3
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Serial bus pins
    input wire logic spi_cs_n,
    input wire logic spi_sck,
    input wire logic spi_sdi,
    output logic spi_sdo_out,
    output logic spi_sdo_oe,
    // Sample-ready pin
    output logic sample_ready_n_out,
    output logic sample_ready_n_oe,
    // Converter side
    input wire logic [23:0] filter_data,
    input wire logic config_crc_mismatch,
    input wire logic [15:0] config_checksum_value,
    output logic converter_restart
);
    adcoi_spi_state_t state_ff;
    logic [1:0] cs_sy_ff;
    logic [2:0] sck_sy_ff;
    logic [1:0] sdi_sy_ff;
    logic [5:0] cnt_ff;
    logic [22:0] rx_ff;
    logic [4:0] addr_ff;
    logic [31:0] tx_ff;
    logic sdo_ff;
    logic [23:0] stage1_ff;
    logic [23:0] stage2_ff;
    logic sample_ready_flag_ff;
    logic [11:0] phase_ff;
    logic [2:0] osr_ff;
    logic [1:0] pre_ff;
    logic soft_rst_ff;
    logic shutdown_ff;
    logic external_reference_select_ff;
    logic external_clock_select_ff;
    logic ready_pin_tristate_sel_ff;
    logic crc_en_ff;
    logic width_data1_ff;
    logic [7:0] lock_key_ff;
    logic [15:0] mod_cnt_ff;
    logic [19:0] conv_cnt_ff;
    logic [15:0] low_cnt_ff;
    logic rdy_out_ff;
    logic rdy_oe_ff;
    logic restart_ff;
    logic cs_act;
    logic sck_rise;
    logic sck_fall;
    logic sdi_s;
    logic wr_commit;
    logic wr_ok;
    logic [23:0] wr_data;
    logic restart_req;
    logic rd_start;
    logic [23:0] word_now;
    logic [15:0] crc_val;
    logic active;
    logic [15:0] mod_period;
    logic [15:0] half_len;
    logic [19:0] osr_len;
    logic [19:0] first_len;
    logic mod_tick;
    logic pulse_start;
    logic ready_low;

    function automatic logic is_writable(input logic [4:0] a, input logic [7:0] key);
        is_writable = (a == `ADCOI_ADDR_LOCK) ||
            ((key == `ADCOI_LOCK_KEY) && (a != `ADCOI_ADDR_RESULT));
    endfunction

    // Pins from the bus master pass two flops before use
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            cs_sy_ff <= 2'h3;
            sck_sy_ff <= 3'h0;
            sdi_sy_ff <= 2'h0;
        end else begin
            cs_sy_ff <= {cs_sy_ff[0], spi_cs_n};
            sck_sy_ff <= {sck_sy_ff[1:0], spi_sck};
            sdi_sy_ff <= {sdi_sy_ff[0], spi_sdi};
        end
    end

    assign cs_act = ~cs_sy_ff[1];
    assign sck_rise = sck_sy_ff[1] & ~sck_sy_ff[2];
    assign sck_fall = ~sck_sy_ff[1] & sck_sy_ff[2];
    assign sdi_s = sdi_sy_ff[1];

    // Serial framing: control byte, then write words or read words
    always_ff @(posedge sys_clk) begin
        if (rst || !cs_act) begin
            state_ff <= ST_IDLE;
            cnt_ff <= 6'h00;
            rx_ff <= 23'h000000;
            addr_ff <= 5'h00;
        end else begin
            unique case (state_ff)
                ST_IDLE: begin
                    state_ff <= ST_CMD;
                    cnt_ff <= 6'h00;
                end
                ST_CMD: begin
                    if (sck_rise) begin
                        rx_ff <= {rx_ff[21:0], sdi_s};
                        cnt_ff <= cnt_ff + 6'h01;
                        if (cnt_ff == `ADCOI_CMD_LAST) begin
                            cnt_ff <= 6'h00;
                            if (rx_ff[6:5] != `ADCOI_DEV_ADDR) begin
                                state_ff <= ST_SKIP;
                            end else if (sdi_s) begin
                                state_ff <= ST_RD;
                            end else begin
                                state_ff <= ST_WR;
                            end
                            addr_ff <= rx_ff[4:0];
                        end
                    end
                end
                ST_WR: begin
                    if (sck_rise) begin
                        rx_ff <= {rx_ff[21:0], sdi_s};
                        cnt_ff <= (cnt_ff == `ADCOI_WORD_LAST) ? 6'h00 : cnt_ff + 6'h01;
                    end
                end
                ST_RD: begin
                    if (sck_fall) begin
                        cnt_ff <= cnt_ff + 6'h01;
                        if (cnt_ff == `ADCOI_WORD_LAST) begin
                            cnt_ff <= 6'h00;
                            state_ff <= crc_en_ff ? ST_CRC : ST_RD;
                        end
                    end
                end
                ST_CRC: begin
                    if (sck_fall) begin
                        cnt_ff <= cnt_ff + 6'h01;
                        if (cnt_ff == (width_data1_ff ? `ADCOI_CRC32_LAST : `ADCOI_CRC16_LAST)) begin
                            cnt_ff <= 6'h00;
                            state_ff <= ST_RD;
                        end
                    end
                end
                ST_SKIP: begin
                    state_ff <= ST_SKIP;
                end
                default: begin
                    state_ff <= ST_IDLE;
                end
            endcase
        end
    end

    // Static address set: one register is the whole read sequence
    assign rd_start = (state_ff == ST_RD) && sck_fall && (cnt_ff == 6'h00);
    assign wr_commit = (state_ff == ST_WR) && sck_rise && (cnt_ff == `ADCOI_WORD_LAST);
    assign wr_data = {rx_ff, sdi_s};
    assign wr_ok = wr_commit && is_writable(addr_ff, lock_key_ff);

    always_comb begin
        unique case (addr_ff)
            `ADCOI_ADDR_RESULT: word_now = stage1_ff;
            `ADCOI_ADDR_PHASE: word_now = {12'h000, phase_ff};
            `ADCOI_ADDR_STATUS: word_now = {20'h00000, width_data1_ff, crc_en_ff, ready_pin_tristate_sel_ff, sample_ready_flag_ff};
            `ADCOI_ADDR_CFG0: word_now = {19'h00000, pre_ff, osr_ff};
            `ADCOI_ADDR_CFG1: word_now = {20'h00000, external_clock_select_ff, external_reference_select_ff, shutdown_ff, soft_rst_ff};
            `ADCOI_ADDR_LOCK: word_now = {lock_key_ff, config_checksum_value};
            default: word_now = 24'h000000;
        endcase
    end

    // CRC-16 over sent bits, cleared per sequence
    adcoi_crc16 u_crc (
        .sys_clk(sys_clk),
        .rst(rst),
        .clr(rd_start),
        .en((state_ff == ST_RD) && sck_fall),
        .din(rd_start ? word_now[23] : tx_ff[31]),
        .crc(crc_val)
    );

    // Data leaves on falling edges; 32-bit checksum is the 16-bit value then zeros
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            tx_ff <= 32'h00000000;
            sdo_ff <= 1'b0;
        end else if (sck_fall && (state_ff == ST_RD) && (cnt_ff == 6'h00)) begin
            sdo_ff <= word_now[23];
            tx_ff <= {word_now[22:0], 9'h000};
        end else if (sck_fall && (state_ff == ST_CRC) && (cnt_ff == 6'h00)) begin
            sdo_ff <= crc_val[15];
            tx_ff <= {crc_val[14:0], 17'h00000};
        end else if (sck_fall && ((state_ff == ST_RD) || (state_ff == ST_CRC))) begin
            sdo_ff <= tx_ff[31];
            tx_ff <= {tx_ff[30:0], 1'b0};
        end
    end

    assign spi_sdo_out = sdo_ff;
    assign spi_sdo_oe = cs_act && ((state_ff == ST_RD) || (state_ff == ST_CRC));

    // Register map writes
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            phase_ff <= `ADCOI_PHASE_RST;
            osr_ff <= `ADCOI_OSR_RST;
            pre_ff <= `ADCOI_PRE_RST;
            {soft_rst_ff, shutdown_ff, external_reference_select_ff} <= 3'h0;
            external_clock_select_ff <= `ADCOI_EXTERNAL_CLOCK_SELECT_RST;
            {crc_en_ff, width_data1_ff} <= 2'h0;
            ready_pin_tristate_sel_ff <= `ADCOI_READY_PIN_TRISTATE_SEL_RST;
            lock_key_ff <= `ADCOI_LOCK_KEY;
        end else if (wr_ok) begin
            unique case (addr_ff)
                `ADCOI_ADDR_PHASE: phase_ff <= wr_data[11:0];
                `ADCOI_ADDR_STATUS: begin
                    ready_pin_tristate_sel_ff <= wr_data[`ADCOI_ST_READY_PIN_TRISTATE_SEL];
                    crc_en_ff <= wr_data[`ADCOI_ST_CRC_EN];
                    width_data1_ff <= wr_data[`ADCOI_ST_WIDTH_DATA1];
                end
                `ADCOI_ADDR_CFG0: begin
                    osr_ff <= wr_data[`ADCOI_CFG0_OSR_LSB +: 3];
                    pre_ff <= wr_data[`ADCOI_CFG0_PRE_LSB +: 2];
                end
                `ADCOI_ADDR_CFG1: begin
                    soft_rst_ff <= wr_data[`ADCOI_CFG1_SOFT_RESET];
                    shutdown_ff <= wr_data[`ADCOI_CFG1_SHUTDOWN];
                    external_reference_select_ff <= wr_data[`ADCOI_CFG1_EXTERNAL_REFERENCE_SELECT];
                    external_clock_select_ff <= wr_data[`ADCOI_CFG1_EXTERNAL_CLOCK_SELECT];
                end
                `ADCOI_ADDR_LOCK: lock_key_ff <= wr_data[`ADCOI_LOCK_LSB +: 8];
                default: lock_key_ff <= lock_key_ff;
            endcase
        end
    end

    // restart triggers, phase rewrite counts even if unchanged
    assign restart_req = wr_ok && ((addr_ff == `ADCOI_ADDR_PHASE) ||
        ((addr_ff == `ADCOI_ADDR_CFG0) &&
            ({wr_data[`ADCOI_CFG0_PRE_LSB +: 2], wr_data[`ADCOI_CFG0_OSR_LSB +: 3]} != {pre_ff, osr_ff})) ||
        ((addr_ff == `ADCOI_ADDR_CFG1) &&
            ({wr_data[`ADCOI_CFG1_EXTERNAL_CLOCK_SELECT], wr_data[`ADCOI_CFG1_EXTERNAL_REFERENCE_SELECT]} != {external_clock_select_ff, external_reference_select_ff})));

    assign active = ~soft_rst_ff & ~shutdown_ff;
    assign mod_period = 16'(MOD_DIV) << pre_ff;
    assign half_len = (mod_period > 16'h0001) ? (mod_period >> 1) : 16'h0001;
    assign osr_len = `ADCOI_OSR_BASE << osr_ff;
    assign first_len = 20'(SETTLE_PERIODS) * osr_len + {8'h00, phase_ff};
    assign mod_tick = (mod_cnt_ff == mod_period - 16'h0001);
    assign pulse_start = active && mod_tick && (conv_cnt_ff == 20'h00000) && !restart_req && !restart_ff;
    assign ready_low = (low_cnt_ff != 16'h0000);

    // settling plus phase first, then one output-rate period apart
    always_ff @(posedge sys_clk) begin
        // Reload once more a cycle later: the write that restarts may also change phase or ratio
        if (rst || restart_req || restart_ff || !active) begin
            mod_cnt_ff <= 16'h0000;
            conv_cnt_ff <= first_len;
        end else begin
            mod_cnt_ff <= mod_tick ? 16'h0000 : mod_cnt_ff + 16'h0001;
            if (mod_tick) begin
                conv_cnt_ff <= (conv_cnt_ff == 20'h00000) ? osr_len - 20'h00001 : conv_cnt_ff - 20'h00001;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst || restart_req) begin
            low_cnt_ff <= 16'h0000;
        end else if (pulse_start) begin
            low_cnt_ff <= half_len;
        end else if (ready_low) begin
            low_cnt_ff <= low_cnt_ff - 16'h0001;
        end
    end

    // pin drive, chip select plays no part
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            rdy_out_ff <= 1'b1;
            rdy_oe_ff <= 1'b0;
            restart_ff <= 1'b0;
        end else begin
            rdy_out_ff <= ~(ready_low | config_crc_mismatch);
            rdy_oe_ff <= ready_low | config_crc_mismatch | ready_pin_tristate_sel_ff;
            restart_ff <= restart_req;
        end
    end

    assign sample_ready_n_out = rdy_out_ff;
    assign sample_ready_n_oe = rdy_oe_ff;
    assign converter_restart = restart_ff;

    always_ff @(posedge sys_clk) begin
        if (rst || restart_req) begin
            stage1_ff <= 24'h000000;
            stage2_ff <= 24'h000000;
        end else begin
            if (pulse_start) begin
                stage1_ff <= filter_data;
            end
            if (rd_start && (addr_ff == `ADCOI_ADDR_RESULT)) begin
                stage2_ff <= stage1_ff;
            end
        end
    end

    // new data shows as 0; a same-cycle read start loses
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            sample_ready_flag_ff <= 1'b1;
        end else if (pulse_start) begin
            sample_ready_flag_ff <= 1'b0;
        end else if (rd_start && (addr_ff == `ADCOI_ADDR_RESULT)) begin
            sample_ready_flag_ff <= 1'b1;
        end
    end

    logic [15:0] low_len_ff;
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            low_len_ff <= 16'h0000;
        end else begin
            low_len_ff <= ready_low ? low_len_ff + 16'h0001 : 16'h0000;
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    sequence s_word_end;
        (state_ff == ST_RD) && sck_fall && (cnt_ff == `ADCOI_WORD_LAST);
    endsequence
    sequence s_enter_crc;
        (state_ff == ST_CRC) && (cnt_ff == 6'h00);
    endsequence

    restart_clears_a: assert property (restart_req |=> stage1_ff == 24'h000000 && stage2_ff == 24'h000000)
        else $error("result not cleared by restart");
    restart_reload_a: assert property (restart_req && active |=> !ready_low ##1 conv_cnt_ff == $past(first_len))
        else $error("converter not restarted");
    pulse_width_a: assert property ($fell(ready_low) && !$past(restart_req) |-> low_len_ff == $past(half_len))
        else $error("sample-ready pulse width wrong");
    idle_drive_a: assert property (!ready_low && !config_crc_mismatch |=> rdy_out_ff && rdy_oe_ff == $past(ready_pin_tristate_sel_ff))
        else $error("idle sample-ready drive wrong");
    mismatch_low_a: assert property (config_crc_mismatch |=> rdy_oe_ff && !rdy_out_ff)
        else $error("mismatch not held low");
    first_latch_a: assert property (pulse_start |=> stage1_ff == $past(filter_data) && ready_low && !sample_ready_flag_ff)
        else $error("first latch or flag missed");
    read_hold_a: assert property ((state_ff == ST_RD) && (cnt_ff != 6'h00) && !restart_req |=> $stable(stage2_ff))
        else $error("result changed during read");
    lock_block_a: assert property (wr_commit && lock_key_ff != `ADCOI_LOCK_KEY && addr_ff != `ADCOI_ADDR_LOCK
        |=> $stable(phase_ff) && $stable(osr_ff) && $stable(ready_pin_tristate_sel_ff))
        else $error("locked write took effect");
    crc_after_a: assert property (s_word_end ##0 crc_en_ff && cs_act |=> s_enter_crc)
        else $error("checksum did not follow sequence");
    first_pulse_a: assert property (!active ##1 active |-> conv_cnt_ff == first_len)
        else $error("first pulse delay not loaded");
endmodule

// ---- verilog/adcoi_cfg.svh ----
// Register offsets, field positions, reset values and counts of the converter output interface
`ifndef ADCOI_CFG_SVH
`define ADCOI_CFG_SVH
`define ADCOI_ADDR_RESULT 5'h00
`define ADCOI_ADDR_PHASE 5'h0a
`define ADCOI_ADDR_STATUS 5'h0b
`define ADCOI_ADDR_CFG0 5'h0c
`define ADCOI_ADDR_CFG1 5'h0d
`define ADCOI_ADDR_LOCK 5'h1f
`define ADCOI_LOCK_KEY 8'ha5
`define ADCOI_LOCK_LSB 16
`define ADCOI_DEV_ADDR 2'h1
`define ADCOI_ST_SAMPLE_READY_FLAG 0
`define ADCOI_ST_READY_PIN_TRISTATE_SEL 1
`define ADCOI_ST_CRC_EN 2
`define ADCOI_ST_WIDTH_DATA1 3
`define ADCOI_CFG0_OSR_LSB 0
`define ADCOI_CFG0_PRE_LSB 3
`define ADCOI_CFG1_SOFT_RESET 0
`define ADCOI_CFG1_SHUTDOWN 1
`define ADCOI_CFG1_EXTERNAL_REFERENCE_SELECT 2
`define ADCOI_CFG1_EXTERNAL_CLOCK_SELECT 3
`define ADCOI_OSR_RST 3'h3
`define ADCOI_PRE_RST 2'h0
`define ADCOI_PHASE_RST 12'h000
`define ADCOI_EXTERNAL_CLOCK_SELECT_RST 1'b1
`define ADCOI_READY_PIN_TRISTATE_SEL_RST 1'b0
`define ADCOI_OSR_BASE 20'h00020
`define ADCOI_CRC_POLY 16'h8005
`define ADCOI_CMD_LAST 6'h07
`define ADCOI_WORD_LAST 6'h17
`define ADCOI_CRC16_LAST 6'h0f
`define ADCOI_CRC32_LAST 6'h1f
`endif

// ---- verilog/adcoi_pkg.sv ----
// Types shared by the converter output interface
package adcoi_pkg;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_CMD = 3'b001,
        ST_WR = 3'b010,
        ST_RD = 3'b011,
        ST_CRC = 3'b100,
        ST_SKIP = 3'b101
    } adcoi_spi_state_t;
endpackage

// ---- verilog/adcoi_crc16.sv ----
// Serial CRC-16 generator, most significant bit first
`timescale 1ns/1ns
`include "adcoi_cfg.svh"
module adcoi_crc16 import adcoi_pkg::*; (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Bit stream
    input wire logic clr,
    input wire logic en,
    input wire logic din,
    // Result
    output logic [15:0] crc
);
    logic [15:0] crc_ff;
    logic [15:0] base;
    logic fb;

    // Clear folds into the first bit so a new sequence costs no extra cycle
    always_comb begin
        base = clr ? 16'h0000 : crc_ff;
        fb = din ^ base[15];
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            crc_ff <= 16'h0000;
        end else if (en) begin
            crc_ff <= {base[14:0], 1'b0} ^ (fb ? `ADCOI_CRC_POLY : 16'h0000);
        end
    end

    assign crc = crc_ff;
endmodule

// ---- tb/adcoi_host_model.sv ----
// Serial bus master model for the converter output interface
`timescale 1ns/1ns
module adcoi_host_model #(
    parameter int HALF = 5
) (
    // Clock
    input wire logic sys_clk,
    // Serial pins
    output logic spi_cs_n,
    output logic spi_sck,
    output logic spi_sdi,
    input wire logic spi_sdo
);
    initial begin
        spi_cs_n = 1'b1;
        spi_sck = 1'b0;
        spi_sdi = 1'b0;
    end

    // Control byte then n data bits, mode 0,0; sdo taken at each rising sck of the data bits
    task automatic frame(input logic [7:0] ctrl, input logic [55:0] tx, input int n, output logic [55:0] rx);
        logic [63:0] sh;
        sh = {ctrl, tx};
        rx = '0;
        @(posedge sys_clk);
        spi_cs_n <= 1'b0;
        repeat (4) @(posedge sys_clk);
        for (int i = 0; i < 8 + n; i++) begin
            spi_sdi <= sh[63 - i];
            repeat (HALF) @(posedge sys_clk);
            spi_sck <= 1'b1;
            if (i >= 8) rx = {rx[54:0], spi_sdo};
            repeat (HALF) @(posedge sys_clk);
            spi_sck <= 1'b0;
        end
        repeat (HALF) @(posedge sys_clk);
        spi_cs_n <= 1'b1;
        // Line no longer carries data once the frame is over
        spi_sdi <= ~spi_sdi;
        repeat (4) @(posedge sys_clk);
    endtask
endmodule

// ---- tb/adc_output_interface_control_bench.sv ----
// Self-checking bench for the converter output interface
`timescale 1ns/1ns
`include "adcoi_cfg.svh"
module adc_output_interface_control_bench;
    localparam int MDIV = 4;
    localparam int PERIOD = 32 * MDIV;
    logic sys_clk, rst, spi_cs_n, spi_sck, spi_sdi, sdo_out, sdo_oe, rdy_out, rdy_oe, conv_restart;
    logic config_crc_mismatch;
    logic [23:0] filter_data, exp_data, e;
    logic [55:0] rx;
    logic ready_q, seen_first;
    int cyc, n_restart, rst_cyc, first_cyc, fall_cyc, prev_fall, n_falls, low_len, width_last;
    int n_fail, num_checks, d0, r0;

    adcoi_top #(.MOD_DIV(MDIV), .SETTLE_PERIODS(1)) u_dut (
        .sys_clk(sys_clk), .rst(rst), .spi_cs_n(spi_cs_n), .spi_sck(spi_sck), .spi_sdi(spi_sdi),
        .spi_sdo_out(sdo_out), .spi_sdo_oe(sdo_oe), .sample_ready_n_out(rdy_out),
        .sample_ready_n_oe(rdy_oe), .filter_data(filter_data), .config_crc_mismatch(config_crc_mismatch),
        .config_checksum_value(16'h3c5a), .converter_restart(conv_restart));
    // Undriven sdo shows the inverse of its last level rather than a stale bit
    adcoi_host_model #(.HALF(5)) u_host (
        .sys_clk(sys_clk), .spi_cs_n(spi_cs_n), .spi_sck(spi_sck), .spi_sdi(spi_sdi),
        .spi_sdo(sdo_oe ? sdo_out : ~sdo_out));

    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end

    task automatic conclude();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    task automatic check(input string name, input logic [55:0] seen, input logic [55:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // Pulse, restart and latch monitor; new filter value after each capture
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        ready_q <= rdy_out;
        if (conv_restart) begin
            n_restart <= n_restart + 1;
            rst_cyc <= cyc;
            seen_first <= 1'b0;
        end
        if (!rdy_out) low_len <= low_len + 1;
        else begin
            if (low_len != 0) width_last <= low_len;
            low_len <= 0;
        end
        if (ready_q && !rdy_out) begin
            n_falls <= n_falls + 1;
            prev_fall <= fall_cyc;
            fall_cyc <= cyc;
            if (!seen_first) first_cyc <= cyc;
            seen_first <= 1'b1;
            exp_data <= filter_data;
            filter_data <= filter_data + 24'h010101;
        end
        if (cyc == 60000) begin
            n_fail++;
            conclude();
        end
    end

    task automatic wr(input logic [4:0] a, input logic [23:0] d);
        u_host.frame({2'b01, a, 1'b0}, {d, 32'h0}, 24, rx);
    endtask

    task automatic rd(input logic [4:0] a, input int n);
        u_host.frame({2'b01, a, 1'b1}, '0, n, rx);
    endtask

    task automatic wait_fall();
        int n0;
        n0 = n_falls;
        for (int i = 0; i < 2000 && n_falls == n0; i++) @(posedge sys_clk);
        #1;
    endtask

    function automatic logic [15:0] crc_of(input logic [39:0] d, input int n);
        logic [15:0] c;
        c = 16'h0000;
        for (int i = n - 1; i >= 0; i--) c = {c[14:0], 1'b0} ^ ((c[15] ^ d[i]) ? 16'h8005 : 16'h0000);
        return c;
    endfunction

    initial begin
        cyc = 0; n_restart = 0; n_falls = 0; low_len = 0; n_fail = 0; num_checks = 0;
        ready_q = 1'b1; seen_first = 1'b0; rst = 1'b1; config_crc_mismatch = 1'b0;
        filter_data = 24'h123456;
        repeat (3) @(posedge sys_clk);
        rst <= 1'b0;
        rd(`ADCOI_ADDR_STATUS, 24);
        check("status", rx, 56'h1);
        rd(`ADCOI_ADDR_CFG0, 24);
        check("cfg0", rx, 56'h3);
        rd(`ADCOI_ADDR_CFG1, 24);
        check("cfg1", rx, 56'h8);
        rd(`ADCOI_ADDR_LOCK, 24);
        check("lock", rx, 56'ha53c5a);
        // ratio change restarts, same value does not
        r0 = n_restart;
        wr(`ADCOI_ADDR_CFG0, 24'h0);
        check("restart", n_restart - r0, 1);
        wr(`ADCOI_ADDR_CFG0, 24'h0);
        check("no restart", n_restart - r0, 1);
        wr(`ADCOI_ADDR_PHASE, 24'h0);
        check("phase restart", n_restart - r0, 2);
        rd(`ADCOI_ADDR_RESULT, 24);
        check("cleared", rx, 56'h0);
        wait_fall();
        d0 = first_cyc - rst_cyc;
        wait_fall();
        check("period", fall_cyc - prev_fall, PERIOD);
        repeat (10) @(posedge sys_clk);
        check("width", width_last, MDIV / 2);
        check("idle oe", rdy_oe, 1'b0);
        // flag 0 once a pulse has landed
        wait_fall();
        rd(`ADCOI_ADDR_STATUS, 24);
        check("flag new", rx[0], 1'b0);
        // read at once after the pulse, no wait for an update delay
        wait_fall();
        e = exp_data;
        // whole result shifted out; a pulse lands mid-read
        rd(`ADCOI_ADDR_RESULT, 24);
        check("result", rx, {32'h0, e});
        // checksum in 16 and 32 bit words
        wr(`ADCOI_ADDR_STATUS, 24'h4);
        wait_fall();
        e = exp_data;
        rd(`ADCOI_ADDR_RESULT, 40);
        check("crc16", rx, {16'h0, e, crc_of({16'h0, e}, 24)});
        check("residue", crc_of(rx[39:0], 40), 16'h0);
        // width bit set with checksum enable: 24-bit data, 32-bit checksum word
        wr(`ADCOI_ADDR_STATUS, 24'hc);
        wait_fall();
        e = exp_data;
        rd(`ADCOI_ADDR_RESULT, 56);
        check("crc32", rx, {e, crc_of({16'h0, e}, 24), 16'h0});
        // tristate select drives the idle pin high
        wr(`ADCOI_ADDR_STATUS, 24'h2);
        wait_fall();
        repeat (10) @(posedge sys_clk);
        check("idle high", {rdy_oe, rdy_out}, 2'b11);
        // phase adds its delay to the first pulse
        wr(`ADCOI_ADDR_PHASE, 24'h8);
        wait_fall();
        check("phase delay", (first_cyc - rst_cyc) - d0, 8 * MDIV);
        // soft reset halts pulses, reference change restarts
        wr(`ADCOI_ADDR_CFG1, 24'h9);
        r0 = n_falls;
        repeat (400) @(posedge sys_clk);
        check("halted", n_falls - r0, 0);
        r0 = n_restart;
        wr(`ADCOI_ADDR_CFG1, 24'hc);
        check("ref restart", n_restart - r0, 1);
        wait_fall();
        check("soft delay", (first_cyc - rst_cyc) - d0, 8 * MDIV);
        // zeros in the key lock the map
        wr(`ADCOI_ADDR_LOCK, 24'h0);
        r0 = n_restart;
        wr(`ADCOI_ADDR_CFG0, 24'h1);
        rd(`ADCOI_ADDR_CFG0, 24);
        check("locked", rx, 56'h0);
        check("locked restart", n_restart - r0, 0);
        rd(`ADCOI_ADDR_LOCK, 24);
        check("key", rx, 56'h003c5a);
        wr(`ADCOI_ADDR_LOCK, 24'ha50000);
        wr(`ADCOI_ADDR_CFG0, 24'h1);
        rd(`ADCOI_ADDR_CFG0, 24);
        check("unlocked", rx, 56'h1);
        @(posedge sys_clk);
        config_crc_mismatch <= 1'b1;
        repeat (2) @(posedge sys_clk);
        r0 = 0;
        for (int i = 0; i < 300; i++) begin
            @(posedge sys_clk);
            #1;
            if (rdy_out === 1'b0 && rdy_oe === 1'b1) r0++;
        end
        check("held low", r0, 300);
        conclude();
    end
endmodule
